// ---- src/lqm_pkg.sv ----
package lqm_pkg;
  // ==========================================================
  // Register map (word offsets)
  localparam logic [11:0] ADDR_CONFIG  = 12'h560;
  localparam logic [11:0] ADDR_TALLIES = 12'h561;
  localparam logic [11:0] ADDR_TRAIN   = 12'h562;
  localparam int          ADDR_W       = 12;
  localparam int          DATA_W       = 16;

  // ==========================================================
  // Config field layout
  localparam int CFG_METRIC_LSB = 11;
  localparam int CFG_METRIC_MSB = 12;
  localparam int CFG_FAIL_LSB   = 5;
  localparam int CFG_FAIL_MSB   = 10;
  localparam int CFG_HYST_LSB   = 3;
  localparam int CFG_HYST_MSB   = 4;
  localparam int CFG_SQI_LSB    = 0;
  localparam int CFG_SQI_MSB    = 2;
  localparam int CFG_RSV13      = 13;

  localparam logic [15:0] CFG_RESET     = 16'h07E4;
  localparam logic [15:0] CFG_WR_MASK   = 16'h3FFF;

  // Failure-cause enable bits, relative to field base
  localparam int FC_SQI    = 0;
  localparam int FC_JABBER = 1;
  localparam int FC_LDOWN  = 2;
  localparam int FC_RXERR  = 3;
  localparam int FC_BADESD = 4;
  localparam int FC_NUM    = 5;

  // ==========================================================
  // Tallies / training layout
  localparam int LOSS_W      = 6;
  localparam int FAIL_W      = 10;
  localparam int TRAIN_W     = 8;
  localparam int READY_BIT   = 15;

  // ==========================================================
  // Link indication select codes
  localparam logic [1:0] SEL_LINKUP  = 2'h0;
  localparam logic [1:0] SEL_MONITOR = 2'h1;
  localparam logic [1:0] SEL_SENDDAT = 2'h2;
  localparam logic [1:0] SEL_COMMRDY = 2'h3;

  // ==========================================================
  // Hysteresis times and derived cycle counts
  localparam longint CLK_HZ     = 10_000_000;
  localparam longint HYST0_US   = 2000;
  localparam longint HYST1_US   = 500;
  localparam longint HYST2_US   = 1000;
  localparam longint HYST3_US   = 4000;
  localparam int     HCNT_W     = 16;
  localparam logic [HCNT_W-1:0] HYST0_CYC =
    HCNT_W'(HYST0_US * CLK_HZ / 1_000_000);
  localparam logic [HCNT_W-1:0] HYST1_CYC =
    HCNT_W'(HYST1_US * CLK_HZ / 1_000_000);
  localparam logic [HCNT_W-1:0] HYST2_CYC =
    HCNT_W'(HYST2_US * CLK_HZ / 1_000_000);
  localparam logic [HCNT_W-1:0] HYST3_CYC =
    HCNT_W'(HYST3_US * CLK_HZ / 1_000_000);
endpackage

// ---- src/lqm_sat_counter.sv ----
`timescale 1ns/1ns
`default_nettype none
module lqm_sat_counter #(
  parameter int W = 6
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         ce_i,
  input  wire logic         inc_i,
  output logic [W-1:0]      count_o
);
  logic [W-1:0] next_count;

  // ==========================================================
  // Saturating count, never cleared by reads
  always_comb begin
    next_count = count_o;
    if (inc_i && (count_o != {W{1'b1}})) begin // [R13]
      next_count = count_o + W'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      count_o <= '0;
    end else if (ce_i) begin
      count_o <= next_count;
    end
  end
endmodule
`default_nettype wire

// ---- src/lqm_monitor.sv ----
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
// How it works
// [R1] Two-bit selector picks the link indication
// [R2] Six failure-cause enables, reset all ones
// [R3] Enable bit 5: signal quality below threshold
// [R4] Enable bit 6: jabber and bad start delimiter
// [R5] Bits 7-9: link down, rx error, bad end
// [R6] Hysteresis select: 2ms, 500us, 1ms, 4ms
// [R7] Three-bit quality threshold, reset 100b
// [R8] Quality crossing increments failure counter
// [R9] Six-bit link loss counter, bits 15-10
// [R10] Ten-bit non-fatal failure counter, bits 9-0
// [R11] Comm-ready flag in training register bit 15
// [R12] Last training duration in bits 7-0
// [R13] Counters saturate, reads do not clear
// [R14] Flag moves after stable full hysteresis
module lqm_monitor (
  input  wire logic                       clk_i,
  input  wire logic                       rst_n_i,
  input  wire logic                       ce_i,
  input  wire logic [lqm_pkg::ADDR_W-1:0] addr_i,
  input  wire logic [lqm_pkg::DATA_W-1:0] wdata_i,
  input  wire logic                       wr_i,
  input  wire logic                       rd_i,
  output logic      [lqm_pkg::DATA_W-1:0] rdata_o,
  input  wire logic                       link_up_i,
  input  wire logic                       link_monitor_i,
  input  wire logic                       send_data_i,
  input  wire logic                       comm_ready_raw_i,
  input  wire logic [2:0]                 sqi_level_i,
  input  wire logic                       receive_overlength_detect_i,
  input  wire logic                       bad_start_delimiter_i,
  input  wire logic                       link_down_state_i,
  input  wire logic                       rx_error_i,
  input  wire logic                       bad_end_delimiter_i,
  input  wire logic                       training_done_i,
  input  wire logic [7:0]                 training_time_i,
  output logic                            comm_ready_o
);
  // ==========================================================
  // Configuration register
  logic [15:0] cfg;
  logic [15:0] next_cfg;
  logic [1:0]  sel;
  logic [5:0]  fail_en;
  logic [1:0]  hyst_sel;
  logic [2:0]  sqi_thr;

  assign sel      = cfg[lqm_pkg::CFG_METRIC_MSB:lqm_pkg::CFG_METRIC_LSB];
  assign fail_en  = cfg[lqm_pkg::CFG_FAIL_MSB:lqm_pkg::CFG_FAIL_LSB];
  assign hyst_sel = cfg[lqm_pkg::CFG_HYST_MSB:lqm_pkg::CFG_HYST_LSB];
  assign sqi_thr  = cfg[lqm_pkg::CFG_SQI_MSB:lqm_pkg::CFG_SQI_LSB];

  always_comb begin
    next_cfg = cfg;
    if (wr_i && addr_i == lqm_pkg::ADDR_CONFIG) begin
      next_cfg = wdata_i & lqm_pkg::CFG_WR_MASK;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cfg <= lqm_pkg::CFG_RESET; // [R2] [R7]
    end else if (ce_i) begin
      cfg <= next_cfg;
    end
  end

  // ==========================================================
  // Pin synchronisers; status arrives from another clock
  localparam int NS = 20;
  logic [NS-1:0] raw_in;
  logic [NS-1:0] sync1;
  logic [NS-1:0] sync2;
  logic [NS-1:0] next_sync1;
  logic [NS-1:0] next_sync2;

  assign raw_in = {training_time_i, sqi_level_i, bad_end_delimiter_i,
                   rx_error_i, link_down_state_i, bad_start_delimiter_i,
                   receive_overlength_detect_i, comm_ready_raw_i,
                   send_data_i, link_monitor_i, link_up_i};

  always_comb begin
    next_sync1 = raw_in;
    next_sync2 = sync1;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sync1 <= '0;
      sync2 <= '0;
    end else if (ce_i) begin
      sync1 <= next_sync1;
      sync2 <= next_sync2;
    end
  end

  // training_done_i is on the core clock: no synchroniser
  logic       s_linkup;
  logic       s_monitor;
  logic       s_senddat;
  logic       s_commrdy;
  logic       s_jabber;
  logic       s_badssd;
  logic       s_ldown;
  logic       s_rxerr;
  logic       s_badesd;
  logic [2:0] s_sqi;
  logic [7:0] s_train;

  assign s_linkup  = sync2[0];
  assign s_monitor = sync2[1];
  assign s_senddat = sync2[2];
  assign s_commrdy = sync2[3];
  assign s_jabber  = sync2[4];
  assign s_badssd  = sync2[5];
  assign s_ldown   = sync2[6];
  assign s_rxerr   = sync2[7];
  assign s_badesd  = sync2[8];
  assign s_sqi     = sync2[11:9];
  assign s_train   = sync2[19:12];

  // ==========================================================
  // Link indication select and hysteresis
  logic        ind;
  logic [lqm_pkg::HCNT_W-1:0] hyst_lim;
  logic [lqm_pkg::HCNT_W-1:0] hcnt;
  logic [lqm_pkg::HCNT_W-1:0] next_hcnt;
  logic        next_comm;

  always_comb begin
    case (sel) // [R1]
      lqm_pkg::SEL_LINKUP:  ind = s_linkup;
      lqm_pkg::SEL_MONITOR: ind = s_monitor;
      lqm_pkg::SEL_SENDDAT: ind = s_senddat;
      lqm_pkg::SEL_COMMRDY: ind = s_commrdy;
      default:              ind = s_linkup;
    endcase
    case (hyst_sel) // [R6]
      2'h0:    hyst_lim = lqm_pkg::HYST0_CYC;
      2'h1:    hyst_lim = lqm_pkg::HYST1_CYC;
      2'h2:    hyst_lim = lqm_pkg::HYST2_CYC;
      2'h3:    hyst_lim = lqm_pkg::HYST3_CYC;
      default: hyst_lim = lqm_pkg::HYST0_CYC;
    endcase
  end

  // A glitch back to the old level restarts the wait
  always_comb begin
    next_hcnt = '0;
    next_comm = comm_ready_o;
    if (ind != comm_ready_o) begin
      if (hcnt >= hyst_lim - lqm_pkg::HCNT_W'(1)) begin // [R14]
        next_comm = ind;
      end else begin
        next_hcnt = hcnt + lqm_pkg::HCNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      hcnt         <= '0;
      comm_ready_o <= 1'b0;
    end else if (ce_i) begin
      hcnt         <= next_hcnt;
      comm_ready_o <= next_comm;
    end
  end

  // ==========================================================
  // Event detection
  logic       sqi_bad;
  logic       sqi_bad_q;
  logic       comm_q;
  logic       next_comm_q;
  logic [4:0] ev;
  logic [4:0] ev_q;
  logic [4:0] next_ev_q;
  logic [2:0] sqi_prev;
  logic [2:0] sqi_use;
  logic [2:0] next_sqi_prev;
  logic [2:0] next_sqi_use;
  logic       fail_ev;
  logic       loss_ev;

  // Quality word syncs bit by bit: take it once two samples agree
  always_comb begin
    next_sqi_prev = s_sqi;
    next_sqi_use  = sqi_use;
    if (s_sqi == sqi_prev) begin
      next_sqi_use = s_sqi;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sqi_prev <= '0;
      sqi_use  <= '0;
    end else if (ce_i) begin
      sqi_prev <= next_sqi_prev;
      sqi_use  <= next_sqi_use;
    end
  end

  // Larger level means worse quality
  assign sqi_bad = (sqi_use > sqi_thr);
  assign ev      = {s_badesd, s_rxerr, s_ldown, s_jabber | s_badssd, sqi_bad};

  always_comb begin
    next_ev_q   = ev;
    next_comm_q = comm_ready_o;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ev_q   <= '0;
      comm_q <= 1'b0;
    end else if (ce_i) begin
      ev_q   <= next_ev_q;
      comm_q <= next_comm_q;
    end
  end

  assign sqi_bad_q = ev_q[lqm_pkg::FC_SQI];
  assign loss_ev   = comm_q && !comm_ready_o; // [R9]

  // Failures during a loss are counted as the loss only
  always_comb begin
    fail_ev = 1'b0;
    if (fail_en[lqm_pkg::FC_SQI] && sqi_bad && !sqi_bad_q) begin // [R3] [R8]
      fail_ev = 1'b1;
    end
    if (fail_en[lqm_pkg::FC_JABBER] && ev[1] && !ev_q[1]) begin // [R4]
      fail_ev = 1'b1;
    end
    for (int i = lqm_pkg::FC_LDOWN; i < lqm_pkg::FC_NUM; i++) begin
      if (fail_en[i] && ev[i] && !ev_q[i]) begin // [R5]
        fail_ev = 1'b1;
      end
    end
    if (!comm_ready_o || loss_ev) begin // [R10]
      fail_ev = 1'b0;
    end
  end

  // ==========================================================
  // Counters
  logic [lqm_pkg::LOSS_W-1:0] loss_cnt;
  logic [lqm_pkg::FAIL_W-1:0] fail_cnt;

  lqm_sat_counter #(.W(lqm_pkg::LOSS_W)) u_loss (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .ce_i    (ce_i),
    .inc_i   (loss_ev),
    .count_o (loss_cnt)
  );

  lqm_sat_counter #(.W(lqm_pkg::FAIL_W)) u_fail (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .ce_i    (ce_i),
    .inc_i   (fail_ev),
    .count_o (fail_cnt)
  );

  // ==========================================================
  // Last training time capture
  logic [lqm_pkg::TRAIN_W-1:0] train;
  logic [lqm_pkg::TRAIN_W-1:0] next_train;

  always_comb begin
    next_train = train;
    if (training_done_i) begin // [R12]
      next_train = s_train;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      train <= '0;
    end else if (ce_i) begin
      train <= next_train;
    end
  end

  // ==========================================================
  // Read path; unmapped addresses read zero
  logic [15:0] next_rdata;

  always_comb begin
    next_rdata = '0;
    if (rd_i) begin
      case (addr_i)
        lqm_pkg::ADDR_CONFIG:  next_rdata = cfg;
        lqm_pkg::ADDR_TALLIES: next_rdata = {loss_cnt, fail_cnt}; // [R9] [R10]
        lqm_pkg::ADDR_TRAIN: begin
          next_rdata[lqm_pkg::READY_BIT]         = comm_ready_o; // [R11]
          next_rdata[lqm_pkg::TRAIN_W-1:0]       = train; // [R12]
        end
        default:               next_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rdata_o <= '0;
    end else if (ce_i) begin
      rdata_o <= next_rdata;
    end
  end
endmodule
`default_nettype wire

// ---- verif/lqm_monitor_properties.sv ----
`timescale 1ns/1ns
`default_nettype none
module lqm_monitor_properties (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [11:0] addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  input  wire logic [15:0] rdata_o,
  input  wire logic        link_up_i,
  input  wire logic        link_monitor_i,
  input  wire logic        send_data_i,
  input  wire logic        comm_ready_raw_i,
  input  wire logic        comm_ready_o
);
  // ======
  // Setup
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  wire any_up = link_up_i | link_monitor_i | send_data_i | comm_ready_raw_i;
  wire all_up = link_up_i & link_monitor_i & send_data_i & comm_ready_raw_i;
  sequence s_cfg_wr_rd;
    wr_i && addr_i == lqm_pkg::ADDR_CONFIG ##1
      rd_i && addr_i == lqm_pkg::ADDR_CONFIG;
  endsequence
  sequence s_train_rd;
    rd_i && addr_i == lqm_pkg::ADDR_TRAIN;
  endsequence
  // ======
  // Checks
  a_cfg_readback: assert property (
    s_cfg_wr_rd |=> rdata_o == ($past(wdata_i, 2) & lqm_pkg::CFG_WR_MASK))
    else $error("config readback wrong");
  a_train_ready: assert property (
    s_train_rd |=> rdata_o[15] == $past(comm_ready_o))
    else $error("ready bit wrong");
  a_train_rsvd: assert property (
    s_train_rd |=> rdata_o[14:8] == 7'h00)
    else $error("training reserved bits set");
  // Shortest hysteresis is thousands of cycles, so eight is safe
  a_ready_hold: assert property (
    $changed(comm_ready_o) |=> $stable(comm_ready_o)[*8])
    else $error("ready toggled too fast");
  a_ready_reset: assert property (
    $rose(rst_n_i) |-> !comm_ready_o)
    else $error("ready high after reset");
  a_rise_cause: assert property (
    $rose(comm_ready_o) |-> $past(any_up, 4))
    else $error("ready rose without link");
  a_fall_cause: assert property (
    $fell(comm_ready_o) |-> !$past(all_up, 4))
    else $error("ready fell with all up");
  a_rise_gap: assert property (
    $rose(comm_ready_o) |-> !$past(comm_ready_o, 200))
    else $error("ready bounced");
endmodule
`default_nettype wire

// ---- verif/lqm_link_partner.sv ----
`timescale 1ns/1ns
`default_nettype none
module lqm_link_partner (
  input  wire logic       clk_i,
  input  wire logic       up_i,
  input  wire logic [3:0] mask_i,
  output logic      [3:0] ind_o
);
  // ======
  // Unmasked indications follow the cable state one cycle late; masked ones stay low
  always_ff @(posedge clk_i) begin
    ind_o <= {4{up_i}} & mask_i;
  end
endmodule
`default_nettype wire

// ---- verif/tb.sv ----
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
  $display("CHECK FAILED %0t got %h exp %h", $time, g, e); end end
module tb;
  logic        clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [11:0] addr_i = 12'h000;
  logic [15:0] wdata_i = 16'h0000;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic        ce = 1'b1;
  logic [15:0] rdata_o;
  logic        up = 1'b0;
  logic [3:0]  mask = 4'h1;
  logic [3:0]  ind;
  logic [4:0]  flt = 5'h00;
  logic [2:0]  sqi = 3'h0;
  logic        tdone = 1'b0;
  logic [7:0]  ttime = 8'h00;
  logic        comm_ready_o;
  logic [31:0] seed = 32'h4609;
  logic [15:0] d;
  logic [5:0]  en;
  int          miscompares = 0;
  int          n_tests = 0;
  int          nloss = 0;
  int          nfail = 0;
  // ======
  // Instances
  lqm_link_partner lp_u (.clk_i(clk_i), .up_i(up), .mask_i(mask), .ind_o(ind));
  lqm_monitor dut_u (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .link_up_i(ind[0]), .link_monitor_i(ind[1]), .send_data_i(ind[2]),
    .comm_ready_raw_i(ind[3]), .sqi_level_i(sqi),
    .receive_overlength_detect_i(flt[0]), .bad_start_delimiter_i(flt[1]),
    .link_down_state_i(flt[2]), .rx_error_i(flt[3]),
    .bad_end_delimiter_i(flt[4]), .training_done_i(tdone),
    .training_time_i(ttime), .comm_ready_o(comm_ready_o));
  initial forever #50 clk_i = ~clk_i;
  // ======
  // Helpers
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [15:0] mk(logic [1:0] s, logic [5:0] e,
                                     logic [1:0] h);
    return {3'b000, s, e, h, 3'b100};
  endfunction
  // Causes 5 and 6 are quality levels above and at the threshold
  function automatic int eb(int c);
    return (c == 0) ? 1 : (c >= 5) ? 0 : c;
  endfunction
  task automatic acc(input logic [11:0] a, input logic [15:0] v);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= v;
    @(posedge clk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    d = rdata_o;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    d = rdata_o;
  endtask
  task automatic link(input logic u, input int n);
    @(posedge clk_i);
    up <= u;
    repeat (n) @(posedge clk_i);
    #1 `CHK(comm_ready_o, ~u)
    repeat (8) @(posedge clk_i);
    #1 `CHK(comm_ready_o, u)
  endtask
  task automatic pulse(input int c);
    @(posedge clk_i);
    if (c >= 5) sqi <= (c == 5) ? 3'h5 : 3'h4;
    else flt[c] <= 1'b1;
    repeat (4) @(posedge clk_i);
    sqi <= 3'h0;
    flt <= 5'h00;
    repeat (4) @(posedge clk_i);
  endtask
  task automatic final_report;
    $display("tests %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ======
  // Tests
  initial begin
    // Planned run is about 92500 cycles
    repeat (96000) @(posedge clk_i);
    miscompares++;
    final_report();
  end
  initial begin
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd(lqm_pkg::ADDR_CONFIG);
    `CHK(d, lqm_pkg::CFG_RESET)
    rd(lqm_pkg::ADDR_TRAIN);
    `CHK(d, 16'h0000)
    rd(12'h563);
    `CHK(d, 16'h0000)
    acc(lqm_pkg::ADDR_TALLIES, 16'hFFFF);
    `CHK(d, 16'h0000)
    repeat (4) begin
      acc(lqm_pkg::ADDR_CONFIG, 16'(xs()));
      `CHK(d, wdata_i & lqm_pkg::CFG_WR_MASK)
    end
    acc(lqm_pkg::ADDR_CONFIG, lqm_pkg::CFG_RESET);
    $display("registers done");
    link(1'b1, 20000);
    for (int r = 0; r < 3; r++) begin
      en = 6'(xs());
      acc(lqm_pkg::ADDR_CONFIG, mk(2'h0, en, 2'h0));
      for (int c = 0; c < 7; c++) begin
        pulse(c);
        if (en[eb(c)] && c < 6) nfail++;
      end
      rd(lqm_pkg::ADDR_TALLIES);
      `CHK(d, {6'h00, 10'(nfail)})
    end
    acc(lqm_pkg::ADDR_CONFIG, lqm_pkg::CFG_RESET);
    // Frozen clock enable must hide a whole fault pulse
    @(posedge clk_i);
    ce <= 1'b0;
    pulse(3);
    ce <= 1'b1;
    rd(lqm_pkg::ADDR_TALLIES);
    `CHK(d, {6'h00, 10'(nfail)})
    // One rising fault edge every two cycles
    repeat (2060) begin
      @(posedge clk_i);
      flt[3] <= ~flt[3];
    end
    repeat (2) begin
      rd(lqm_pkg::ADDR_TALLIES);
      `CHK(d, 16'h03FF)
    end
    $display("failures done");
    @(posedge clk_i);
    ttime <= 8'(xs());
    repeat (4) @(posedge clk_i);
    tdone <= 1'b1;
    @(posedge clk_i);
    tdone <= 1'b0;
    rd(lqm_pkg::ADDR_TRAIN);
    `CHK(d, {8'h80, ttime})
    $display("training done");
    acc(lqm_pkg::ADDR_CONFIG, mk(2'h0, 6'h3F, 2'h2));
    link(1'b0, 10000);
    for (int s = 0; s < 4; s++) begin
      acc(lqm_pkg::ADDR_CONFIG, mk(2'(s), 6'h3F, 2'h1));
      mask <= 4'h1 << s;
      link(1'b1, 5000);
      link(1'b0, 5000);
    end
    nloss = 5;
    rd(lqm_pkg::ADDR_TALLIES);
    `CHK(d, {6'(nloss), 10'h3FF})
    // Longest setting must outlast the 2 ms one
    acc(lqm_pkg::ADDR_CONFIG, mk(2'h3, 6'h3F, 2'h3));
    @(posedge clk_i);
    up <= 1'b1;
    repeat (20010) @(posedge clk_i);
    #1 `CHK(comm_ready_o, 1'b0)
    $display("selector done");
    final_report();
  end
endmodule
bind lqm_monitor lqm_monitor_properties chk_u (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .link_up_i(link_up_i),
  .link_monitor_i(link_monitor_i), .send_data_i(send_data_i),
  .comm_ready_raw_i(comm_ready_raw_i), .comm_ready_o(comm_ready_o));
`default_nettype wire
